// ### design/pxc_ext_ctrl.sv
// extended control register of the phy with its steering outputs
// Overview of operation
// - override-write enable clears itself after the next write to another register
// - reserved bits 14:11, 4 and 1 read back as zero
// - hardware reset samples five address pins into bits 10:6
// - software reset leaves the latched port address alone
// - scrambler test bit forces loss of lock; clear restores; resets zero
// - 100 Mb/s stream is nrz when bit 3 zero, nrzi when one
// - invalid-code bit zero gives standard 4b/5b; resets zero
// - test with tx error: nibbles 0-7 send 0 plus nibble, 8 sends 00000
// - test with tx error: nibbles 9-f use the listed special codes
// - scrambler disable bypasses both scrambler and descrambler
// - scrambling only applies in 100 Mb/s operation
module pxc_ext_ctrl (
    // clock, reset and enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sw_reset,
    // management register access
    input wire logic [4:0] mgmt_addr,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    // override-protected bit of another register
    input wire logic [4:0] prot_addr,
    input wire logic prot_wdata,
    output logic override_protected_bit,
    // multiplexed address/led pins
    input wire logic addr4_led_pin,
    input wire logic addr3_led_pin,
    input wire logic addr2_led_pin,
    input wire logic addr1_led_pin,
    input wire logic addr0_led_pin,
    // datapath control
    input wire logic speed_100,
    output logic scr_tx_en,
    output logic descr_rx_en,
    output logic force_unlock,
    output logic [4:0] port_addr,
    // transmit nibble path
    input wire logic [3:0] tx_nibble,
    input wire logic tx_err,
    input wire logic tx_valid,
    output logic [4:0] tx_code,
    output logic tx_line
);
    logic ovr_q, ovr_d;
    logic scr_test_q, scr_test_d;
    logic nrzi_q, nrzi_d;
    logic inv_q, inv_d;
    logic scr_dis_q, scr_dis_d;
    logic [4:0] paddr_q, paddr_d;
    logic strap_pend_q, strap_pend_d;
    logic prot_q, prot_d;
    logic [15:0] rdata_q, rdata_d;
    logic scr_tx_q, scr_tx_d;
    logic descr_q, descr_d;
    logic unlock_q, unlock_d;
    logic hit;
    logic [15:0] img;

    assign hit = mgmt_addr == pxc_pkg::EXT_CTRL_ADDR;

    // register image, reserved bits always zero
    always_comb begin
        img = 16'h0000;
        img[pxc_pkg::OVR_WR_EN_BIT] = ovr_q;
        img[pxc_pkg::PORT_ADDR_LSB +: pxc_pkg::PORT_ADDR_W] = paddr_q;
        img[pxc_pkg::SCR_TEST_BIT] = scr_test_q;
        img[pxc_pkg::NRZI_SEL_BIT] = nrzi_q;
        img[pxc_pkg::INV_CODE_BIT] = inv_q;
        img[pxc_pkg::SCR_DIS_BIT] = scr_dis_q;
    end

    // next state of the writable bits and the one-shot enable
    always_comb begin
        ovr_d = ovr_q;
        scr_test_d = scr_test_q;
        nrzi_d = nrzi_q;
        inv_d = inv_q;
        scr_dis_d = scr_dis_q;
        prot_d = prot_q;
        if (sw_reset) begin
            // soft reset restores control bits but not the address
            ovr_d = pxc_pkg::OVR_WR_EN_RST;
            scr_test_d = pxc_pkg::SCR_TEST_RST;
            nrzi_d = pxc_pkg::NRZI_SEL_RST;
            inv_d = pxc_pkg::INV_CODE_RST;
            scr_dis_d = pxc_pkg::SCR_DIS_RST;
        end else if (mgmt_wr) begin
            // any write consumes the enable; one to here loads it from bit 15
            ovr_d = 1'b0;
            if (hit) begin
                ovr_d = mgmt_wdata[pxc_pkg::OVR_WR_EN_BIT];
                scr_test_d = mgmt_wdata[pxc_pkg::SCR_TEST_BIT];
                nrzi_d = mgmt_wdata[pxc_pkg::NRZI_SEL_BIT];
                inv_d = mgmt_wdata[pxc_pkg::INV_CODE_BIT];
                scr_dis_d = mgmt_wdata[pxc_pkg::SCR_DIS_BIT];
            end
            if (mgmt_addr == prot_addr && ovr_q) begin
                prot_d = prot_wdata;
            end
        end
    end

    // port address strap: first enabled edge after hardware reset
    always_comb begin
        paddr_d = paddr_q;
        strap_pend_d = strap_pend_q;
        if (strap_pend_q) begin
            paddr_d = {addr4_led_pin, addr3_led_pin, addr2_led_pin,
                       addr1_led_pin, addr0_led_pin};
            strap_pend_d = 1'b0;
        end
    end

    // read data and datapath controls, all registered
    always_comb begin
        rdata_d = rdata_q;
        if (mgmt_rd) begin
            rdata_d = hit ? img : 16'h0000;
        end
        // scrambler only counts at 100 Mb/s
        scr_tx_d = speed_100 && !scr_dis_q;
        descr_d = speed_100 && !scr_dis_q;
        unlock_d = scr_test_q;
    end

    // register stage; software reset does not reach the address strap
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ovr_q <= pxc_pkg::OVR_WR_EN_RST;
            scr_test_q <= pxc_pkg::SCR_TEST_RST;
            nrzi_q <= pxc_pkg::NRZI_SEL_RST;
            inv_q <= pxc_pkg::INV_CODE_RST;
            scr_dis_q <= pxc_pkg::SCR_DIS_RST;
            paddr_q <= pxc_pkg::PORT_ADDR_RST;
            strap_pend_q <= 1'b1;
            prot_q <= 1'b0;
            rdata_q <= 16'h0000;
            scr_tx_q <= 1'b0;
            descr_q <= 1'b0;
            unlock_q <= 1'b0;
        end else if (clk_en) begin
            ovr_q <= ovr_d;
            scr_test_q <= scr_test_d;
            nrzi_q <= nrzi_d;
            inv_q <= inv_d;
            scr_dis_q <= scr_dis_d;
            paddr_q <= paddr_d;
            strap_pend_q <= strap_pend_d;
            prot_q <= prot_d;
            rdata_q <= rdata_d;
            scr_tx_q <= scr_tx_d;
            descr_q <= descr_d;
            unlock_q <= unlock_d;
        end
    end

    assign mgmt_rdata = rdata_q;
    assign override_protected_bit = prot_q;
    assign port_addr = paddr_q;
    assign scr_tx_en = scr_tx_q;
    assign descr_rx_en = descr_q;
    assign force_unlock = unlock_q;

    // translation and line coding
    pxc_encoder u_enc (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .inv_code(inv_q),
        .nrzi_sel(nrzi_q),
        .speed_100(speed_100),
        .tx_nibble(tx_nibble),
        .tx_err(tx_err),
        .tx_valid(tx_valid),
        .tx_code(tx_code),
        .tx_line(tx_line)
    );

    // a write to another register always consumes the enable
    sequence ovr_armed_s;
        clk_en && !sw_reset && ovr_q;
    endsequence
    sequence other_write_s;
        mgmt_wr && !hit;
    endsequence
    ovr_selfclr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ovr_armed_s and other_write_s |=> !ovr_q)
        else $error("override enable did not clear");
    prot_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && !ovr_q |=> $stable(prot_q))
        else $error("protected bit changed while locked");
    prot_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && ovr_q && !sw_reset && mgmt_wr && mgmt_addr == prot_addr
        |=> prot_q == $past(prot_wdata))
        else $error("override write not applied");
    rsvd_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (mgmt_rdata & ~pxc_pkg::RW_MASK & 16'h7800) == 16'h0000
        && mgmt_rdata[4] == 1'b0 && mgmt_rdata[1] == 1'b0)
        else $error("reserved bit read nonzero");
    strap_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && strap_pend_q |=> paddr_q == $past({addr4_led_pin,
        addr3_led_pin, addr2_led_pin, addr1_led_pin, addr0_led_pin}))
        else $error("port address not strapped");
    addr_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !strap_pend_q |=> $stable(paddr_q))
        else $error("port address changed after strap");
    unlock_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && scr_test_q |=> force_unlock)
        else $error("test mode did not drop lock");
    scr_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en |=> scr_tx_en == ($past(speed_100) && !$past(scr_dis_q))
        && descr_rx_en == scr_tx_en)
        else $error("scrambler enable wrong");
    std_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && speed_100 && tx_valid && !inv_q && tx_nibble == 4'h0
        && u_enc.cnt_q == 3'd0 |=> tx_code == 5'h1e)
        else $error("standard code wrong");
    inv_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && speed_100 && tx_valid && inv_q && tx_err
        && tx_nibble == 4'h9 && u_enc.cnt_q == 3'd0 |=> tx_code == 5'h0d)
        else $error("invalid test code wrong");
    inv_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && speed_100 && tx_valid && inv_q && tx_err
        && tx_nibble == 4'h3 && u_enc.cnt_q == 3'd0 |=> tx_code == 5'h03)
        else $error("low nibble test code wrong");
endmodule : pxc_ext_ctrl

// ### design/pxc_pkg.sv
// package: register map, fields, reset values and code tables for pxc
package pxc_pkg;
    // register offsets
    localparam logic [4:0] EXT_CTRL_ADDR = 5'h10;
    // field positions
    localparam int OVR_WR_EN_BIT = 15;
    localparam int PORT_ADDR_LSB = 6;
    localparam int PORT_ADDR_W = 5;
    localparam int SCR_TEST_BIT = 5;
    localparam int NRZI_SEL_BIT = 3;
    localparam int INV_CODE_BIT = 2;
    localparam int SCR_DIS_BIT = 0;
    // writable bits that feed logic; of the rest only the port address reads nonzero
    localparam logic [15:0] RW_MASK = 16'h802d;
    // reset values
    localparam logic OVR_WR_EN_RST = 1'b0;
    localparam logic SCR_TEST_RST = 1'b0;
    localparam logic NRZI_SEL_RST = 1'b1;
    localparam logic INV_CODE_RST = 1'b0;
    localparam logic SCR_DIS_RST = 1'b0;
    localparam logic [4:0] PORT_ADDR_RST = 5'h00;

    // nibble to 5-bit code, test translation when the test is active
    function automatic logic [4:0] nib_to_code(input logic [3:0] nib,
                                               input logic inv_test);
        logic [4:0] c;
        c = 5'h00;
        if (inv_test) begin
            case (nib)
                4'h8: c = 5'h00;
                4'h9: c = 5'h0d;
                4'ha: c = 5'h0c;
                4'hb: c = 5'h11;
                4'hc: c = 5'h10;
                4'hd: c = 5'h19;
                4'he: c = 5'h18;
                4'hf: c = 5'h1f;
                default: c = {1'b0, nib};
            endcase
        end else begin
            case (nib)
                4'h0: c = 5'h1e;
                4'h1: c = 5'h09;
                4'h2: c = 5'h14;
                4'h3: c = 5'h15;
                4'h4: c = 5'h0a;
                4'h5: c = 5'h0b;
                4'h6: c = 5'h0e;
                4'h7: c = 5'h0f;
                4'h8: c = 5'h12;
                4'h9: c = 5'h13;
                4'ha: c = 5'h16;
                4'hb: c = 5'h17;
                4'hc: c = 5'h1a;
                4'hd: c = 5'h1b;
                4'he: c = 5'h1c;
                default: c = 5'h1d;
            endcase
        end
        return c;
    endfunction : nib_to_code
endpackage : pxc_pkg

// ### design/pxc_encoder.sv
// transmit nibble translation and nrz/nrzi line coding for pxc
module pxc_encoder (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // control from the register and the speed input
    input wire logic inv_code,
    input wire logic nrzi_sel,
    input wire logic speed_100,
    // transmit nibble
    input wire logic [3:0] tx_nibble,
    input wire logic tx_err,
    input wire logic tx_valid,
    // coded outputs
    output logic [4:0] tx_code,
    output logic tx_line
);
    logic [4:0] code_q, code_d;
    logic [4:0] sh_q, sh_d;
    logic [2:0] cnt_q, cnt_d;
    logic line_q, line_d;
    logic bit_now;

    // next code and serialiser state
    always_comb begin
        code_d = code_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        line_d = line_q;
        bit_now = sh_q[4];
        if (speed_100) begin
            if (cnt_q == 3'd0) begin
                if (tx_valid) begin
                    code_d = pxc_pkg::nib_to_code(tx_nibble,
                                                  inv_code && tx_err);
                    sh_d = code_d;
                    cnt_d = 3'd5;
                end
            end else begin
                // nrzi toggles on one, nrz follows the bit
                line_d = nrzi_sel ? (line_q ^ bit_now) : bit_now;
                sh_d = {sh_q[3:0], 1'b0};
                cnt_d = cnt_q - 3'd1;
            end
        end
    end

    // register stage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            code_q <= 5'h00;
            sh_q <= 5'h00;
            cnt_q <= 3'd0;
            line_q <= 1'b0;
        end else if (clk_en) begin
            code_q <= code_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            line_q <= line_d;
        end
    end

    assign tx_code = code_q;
    assign tx_line = line_q;

    tx_nrz_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && speed_100 && cnt_q != 3'd0 && !nrzi_sel
        |=> line_q == $past(sh_q[4]))
        else $error("nrz line bit wrong");
    tx_nrzi_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && speed_100 && cnt_q != 3'd0 && nrzi_sel
        |=> line_q == ($past(line_q) ^ $past(sh_q[4])))
        else $error("nrzi line bit wrong");
endmodule : pxc_encoder

// ### bench/pxc_sta_model.sv
// management entity model driving the register bus of pxc
module pxc_sta_model (
    // clock
    input wire logic mclk,
    // register bus
    output logic [4:0] mgmt_addr,
    output logic mgmt_wr,
    output logic mgmt_rd,
    output logic [15:0] mgmt_wdata,
    // protected bit held in another register
    output logic [4:0] prot_addr,
    output logic prot_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus at time zero; protected bit sits at address 0
    initial begin
        mgmt_addr = 5'h1f;
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        mgmt_wdata = 16'h0000;
        prot_addr = 5'h00;
        prot_wdata = 1'b0;
    end

    // one access; request held across the taking edge, then released
    task automatic cyc(input logic w, input logic [4:0] a,
                       input logic [15:0] d);
        @(posedge mclk);
        #2;
        mgmt_addr = a;
        mgmt_wdata = d;
        mgmt_wr = w;
        mgmt_rd = !w;
        @(posedge mclk);
        #2;
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        mgmt_wdata = ~d; // released data must not look valid
        mgmt_addr = ~a;
    endtask : cyc

    // normal write keeps reserved bits at their zero default
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        cyc(1'b1, a, (a == 5'h10) ? (d & 16'h87ed) : d);
    endtask : wr

    // arm the override, then write the protected register once
    task automatic ovr(input logic [15:0] cur, input logic v);
        wr(5'h10, cur | 16'h8000);
        prot_wdata = v;
        wr(prot_addr, 16'h0000);
    endtask : ovr
endmodule : pxc_sta_model

// ### bench/test_phy_extended_control.sv
// self-checking bench for the pxc extended control register
module test_phy_extended_control;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk, rst_n, clk_en, sw_reset, speed_100, tx_err, tx_valid;
    logic [4:0] mgmt_addr, prot_addr, port_addr, tx_code, pins, pa;
    logic mgmt_wr, mgmt_rd, prot_wdata, override_protected_bit;
    logic [15:0] mgmt_wdata, mgmt_rdata;
    logic scr_tx_en, descr_rx_en, force_unlock, tx_line, rd_f, tx_f;
    logic [3:0] tx_nibble;
    int fail_count = 0;
    int cmp_count = 0;
    logic [15:0] rd_q[$];
    logic [5:0] tx_q[$];
    // expected code tables: standard and invalid-code test
    logic [4:0] std_t[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
        5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c,
        5'h1d};
    logic [4:0] inv_t[16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
        5'h06, 5'h07, 5'h00, 5'h0d, 5'h0c, 5'h11, 5'h10, 5'h19, 5'h18,
        5'h1f};

    pxc_ext_ctrl i_pxc_ext_ctrl (.mclk(mclk), .rst_n(rst_n),
        .clk_en(clk_en), .sw_reset(sw_reset), .mgmt_addr(mgmt_addr),
        .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
        .mgmt_rdata(mgmt_rdata), .prot_addr(prot_addr),
        .prot_wdata(prot_wdata),
        .override_protected_bit(override_protected_bit),
        .addr4_led_pin(pins[4]), .addr3_led_pin(pins[3]),
        .addr2_led_pin(pins[2]), .addr1_led_pin(pins[1]),
        .addr0_led_pin(pins[0]), .speed_100(speed_100),
        .scr_tx_en(scr_tx_en), .descr_rx_en(descr_rx_en),
        .force_unlock(force_unlock), .port_addr(port_addr),
        .tx_nibble(tx_nibble), .tx_err(tx_err), .tx_valid(tx_valid),
        .tx_code(tx_code), .tx_line(tx_line));

    pxc_sta_model i_pxc_sta_model (.mclk(mclk), .mgmt_addr(mgmt_addr),
        .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
        .prot_addr(prot_addr), .prot_wdata(prot_wdata));

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time,
                     seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // expected register image: writable bits plus latched address
    function automatic logic [15:0] rv(input logic [15:0] b);
        return (b & 16'h802d) | {5'h00, pa, 6'h00};
    endfunction : rv

    task automatic rd_exp(input logic [15:0] e);
        rd_q.push_back(e);
        i_pxc_sta_model.cyc(1'b0, 5'h10, 16'h0000);
    endtask : rd_exp

    task automatic hw_reset();
        rst_n = 1'b0;
        repeat (3) @(posedge mclk);
        #2;
        rst_n = 1'b1;
    endtask : hw_reset

    task automatic send(input logic [3:0] n, input logic nrzi,
                        input logic [4:0] code);
        tx_q.push_back({nrzi, code});
        @(posedge mclk);
        #2;
        tx_nibble = n;
        tx_valid = 1'b1;
        @(posedge mclk);
        #2;
        tx_valid = 1'b0;
        tx_nibble = 4'($urandom);
        repeat (6) @(posedge mclk);
    endtask : send

    // result watcher: flags taken on the edge, values checked mid-cycle
    always @(posedge mclk) begin
        rd_f <= mgmt_rd & clk_en;
        tx_f <= tx_valid & speed_100;
    end
    always @(negedge mclk) begin
        logic [5:0] e;
        logic lvl;
        if (rd_f) begin
            chk(mgmt_rdata, rd_q.pop_front());
        end
        if (tx_f) begin
            e = tx_q.pop_front();
            chk(tx_code, e[4:0]);
            lvl = tx_line;
            for (int i = 4; i >= 0; i--) begin
                @(negedge mclk);
                lvl = e[5] ? (lvl ^ e[i]) : e[i];
                chk(tx_line, lvl);
            end
        end
    end

    // watchdog well beyond the expected run
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        sw_reset = 1'b0;
        speed_100 = 1'b1;
        tx_err = 1'b0;
        tx_valid = 1'b0;
        tx_nibble = 4'h0;
        void'($urandom(32'h208d762b));
        pins = 5'($urandom);
        pa = pins;
        hw_reset();
        rd_exp(rv(16'h0008));
        chk(override_protected_bit, 1'b0);
        chk(scr_tx_en, 1'b1);
        $display("test reset_values done");
        // reserved bits written as ones on purpose
        i_pxc_sta_model.cyc(1'b1, 5'h10, 16'h7fff);
        rd_exp(rv(16'h7fff));
        chk(force_unlock, 1'b1);
        chk({scr_tx_en, descr_rx_en}, 2'b00);
        i_pxc_sta_model.wr(5'h10, 16'h0000);
        rd_exp(rv(16'h0000));
        chk({scr_tx_en, descr_rx_en, force_unlock}, 3'b110);
        speed_100 = 1'b0;
        repeat (2) @(posedge mclk);
        #2;
        chk({scr_tx_en, descr_rx_en}, 2'b00);
        speed_100 = 1'b1;
        $display("test field_control done");
        i_pxc_sta_model.prot_wdata = 1'b1;
        i_pxc_sta_model.wr(5'h00, 16'h0000);
        chk(override_protected_bit, 1'b0);
        i_pxc_sta_model.wr(5'h10, 16'h8008);
        rd_exp(rv(16'h8008));
        i_pxc_sta_model.wr(5'h00, 16'h0000);
        chk(override_protected_bit, 1'b1);
        rd_exp(rv(16'h0008));
        i_pxc_sta_model.prot_wdata = 1'b0;
        i_pxc_sta_model.wr(5'h00, 16'h0000);
        chk(override_protected_bit, 1'b1);
        $display("test override done");
        i_pxc_sta_model.wr(5'h10, 16'h002d);
        pins = ~pins;
        @(posedge mclk);
        #2;
        sw_reset = 1'b1;
        @(posedge mclk);
        #2;
        sw_reset = 1'b0;
        rd_exp(rv(16'h0008));
        hw_reset();
        pa = pins;
        rd_exp(rv(16'h0008));
        chk(port_addr, pa);
        $display("test resets done");
        // standard, invalid-code test, and test bit without error
        for (int m = 0; m < 3; m++) begin
            i_pxc_sta_model.wr(5'h10, (m == 0) ? 16'h0000 : 16'h000c);
            for (int n = 0; n < 16; n++) begin
                tx_err = (m == 0) ? 1'($urandom) : (m == 1);
                send(4'(n), m != 0, (m == 1) ? inv_t[n] : std_t[n]);
            end
        end
        $display("test transmit_codes done");
        repeat (4) @(posedge mclk);
        end_of_test();
    end
endmodule : test_phy_extended_control
